// ### src/bps_pkg.sv
// Constants, register map and carrier types for the bus port pin function select block.
// Assumes a 32-bit APB slave port clocked by pclk at 100 MHz.
package bps_pkg;

  // ----------------------------------------------------------------
  // Bus and port widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned PORT_W   = 8;
  localparam int unsigned MODE_W   = 3;
  localparam int unsigned DBUS_W   = 16;
  localparam int unsigned IRQ_W    = 4;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_UPPER_DIR   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_UPPER_DATA  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_UPPER_PINS  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_LOWER_DIR   = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_LOWER_DATA  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_LOWER_PINS  = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_CTRLP_DIR   = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_CTRLP_DATA  = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_CTRLP_PINS  = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_BUS_CTRL    = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_STATUS      = 8'h28;

  // ----------------------------------------------------------------
  // Control port pin positions
  // ----------------------------------------------------------------
  localparam int unsigned PIN_CLK   = 7;
  localparam int unsigned PIN_AS    = 6;
  localparam int unsigned PIN_RD    = 5;
  localparam int unsigned PIN_HWR   = 4;
  localparam int unsigned PIN_LWR   = 3;
  localparam int unsigned PIN_WAIT  = 2;
  localparam int unsigned PIN_GRANT = 1;
  localparam int unsigned PIN_BUS_REQUEST_IN  = 0;

  // ----------------------------------------------------------------
  // Reset values and mode codes
  // ----------------------------------------------------------------
  localparam logic [PORT_W-1:0] DIR_RESET   = 8'h00;
  localparam logic [PORT_W-1:0] DATA_RESET  = 8'h00;
  localparam logic [MODE_W-1:0] MODE_RESET  = 3'h7;
  localparam logic [MODE_W-1:0] MODE_SC_A   = 3'h3;
  localparam logic [MODE_W-1:0] MODE_SC_B   = 3'h7;
  localparam logic [MODE_W-1:0] MODE_NONE   = 3'h0;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic bus_width_16;
    logic bus_release_enable;
    logic bus_request_out_enable;
    logic wait_input_enable;
  } bps_ctrl_s;

  localparam logic [3:0] CTRL_RESET = 4'h0;

  typedef struct packed {
    logic [PORT_W-1:0] out;
    logic [PORT_W-1:0] oe;
  } bps_pad_s;

  typedef struct packed {
    logic [DBUS_W-1:0] data_out;
    logic              data_oe;
    logic              addr_strobe;
    logic              read_strobe;
    logic              high_byte_write_strobe;
    logic              low_byte_write_strobe;
    logic              bus_request_out;
    logic              bus_grant_out;
    logic              sys_clk_level;
  } bps_core_s;

endpackage : bps_pkg

// ### src/bps_mode_decode.sv
// Operating mode decoder: expanded bus modes against single-chip modes.
// Assumes a static three-bit mode code; code 0 is not a legal mode.
`timescale 1ns/1ps
module bps_mode_decode
(
  input  wire logic [bps_pkg::MODE_W-1:0] mode,
  output logic                            expanded,
  output logic                            legal
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Unused code falls back to single-chip so no pin drives a bus
  always_comb
  begin
    legal    = (mode != bps_pkg::MODE_NONE);
    expanded = legal && (mode != bps_pkg::MODE_SC_A) && (mode != bps_pkg::MODE_SC_B);
  end

endmodule : bps_mode_decode

// ### src/bps_port_mux.sv
// Per-bit pin multiplexer between a dedicated function and general I/O.
// Assumes function selects and direction bits are stable registers.
`timescale 1ns/1ps
module bps_port_mux
(
  input  wire logic [bps_pkg::PORT_W-1:0] func_en,
  input  wire logic [bps_pkg::PORT_W-1:0] func_out,
  input  wire logic [bps_pkg::PORT_W-1:0] func_oe,
  input  wire logic [bps_pkg::PORT_W-1:0] dir,
  input  wire logic [bps_pkg::PORT_W-1:0] data,
  output bps_pkg::bps_pad_s               pad
);

  // ----------------------------------------------------------------
  // Per-bit selection
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < bps_pkg::PORT_W; i++)
    begin : g_bit
      assign pad.out[i] = func_en[i] ? func_out[i] : data[i];
      assign pad.oe[i]  = func_en[i] ? func_oe[i]  : dir[i]; // [R12]
    end
  endgenerate

endmodule : bps_port_mux

// ### src/bps_pin_select.sv
// Pin function select for the upper data, lower data and control ports.
// Assumes pin inputs synchronous to pclk, a static mode strap, and an APB master.
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps

// Functional notes
// [R01] Upper port is data bus in expanded modes
// [R02] Lower port data bus only with 16-bit width
// [R03] Clock pin direction bit; reset value follows mode
// [R04] Expanded modes dedicate four strobe pins
// [R05] Single-chip: low four pins also feed interrupts
// [R06] Wait and request off: bit 2 general I/O
// [R07] Wait enabled: bit 2 is wait input
// [R08] Request output enabled: bit 2 drives request
// [R09] Release disabled: bits 1, 0 general I/O
// [R10] Release enabled: request in, grant out
// [R11] Bits 1, 0 always feed interrupts
// [R12] General I/O direction follows its bit
// [R13] Mode latched at reset, classified expanded/single
module bps_pin_select
(
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [bps_pkg::ADDR_W-1:0]      paddr,
  input  wire logic [bps_pkg::DATA_W-1:0]      pwdata,
  output logic      [bps_pkg::DATA_W-1:0]      prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  input  wire logic [bps_pkg::MODE_W-1:0]      mode_pins,
  input  wire bps_pkg::bps_core_s              core,
  input  wire logic [bps_pkg::PORT_W-1:0]      upper_pin_in,
  output logic      [bps_pkg::PORT_W-1:0]      upper_pin_out,
  output logic      [bps_pkg::PORT_W-1:0]      upper_pin_oe,
  input  wire logic [bps_pkg::PORT_W-1:0]      lower_pin_in,
  output logic      [bps_pkg::PORT_W-1:0]      lower_pin_out,
  output logic      [bps_pkg::PORT_W-1:0]      lower_pin_oe,
  input  wire logic [bps_pkg::PORT_W-1:0]      ctrl_pin_in,
  output logic      [bps_pkg::PORT_W-1:0]      ctrl_pin_out,
  output logic      [bps_pkg::PORT_W-1:0]      ctrl_pin_oe,
  output logic      [bps_pkg::DBUS_W-1:0]      data_bus_in,
  output logic                                 wait_in,
  output logic                                 bus_request_in,
  output logic      [bps_pkg::IRQ_W-1:0]       ext_interrupt
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                          init_done;
    logic [bps_pkg::MODE_W-1:0]    mode;
    logic [bps_pkg::PORT_W-1:0]    upper_dir;
    logic [bps_pkg::PORT_W-1:0]    upper_data;
    logic [bps_pkg::PORT_W-1:0]    lower_dir;
    logic [bps_pkg::PORT_W-1:0]    lower_data;
    logic [bps_pkg::PORT_W-1:0]    ctrl_dir;
    logic [bps_pkg::PORT_W-1:0]    ctrl_data;
    bps_pkg::bps_ctrl_s            bus_ctrl;
    logic                          pready;
    logic                          pslverr;
    logic [bps_pkg::DATA_W-1:0]    prdata;
    bps_pkg::bps_pad_s             upper_pad;
    bps_pkg::bps_pad_s             lower_pad;
    bps_pkg::bps_pad_s             ctrl_pad;
    logic [bps_pkg::DBUS_W-1:0]    data_bus_in;
    logic                          wait_in;
    logic                          bus_request_in;
    logic [bps_pkg::IRQ_W-1:0]     ext_interrupt;
  } bps_state_s;

  bps_state_s st;
  bps_state_s next_st;

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  logic expanded;
  logic mode_legal;
  logic strap_expanded;
  logic strap_legal;

  bps_mode_decode u_mode_run
  (
    .mode     (st.mode),
    .expanded (expanded),
    .legal    (mode_legal)
  );

  // Strap decode only used in the capture cycle
  bps_mode_decode u_mode_strap
  (
    .mode     (mode_pins),
    .expanded (strap_expanded),
    .legal    (strap_legal)
  );

  // ----------------------------------------------------------------
  // Function selects
  // ----------------------------------------------------------------
  logic [bps_pkg::PORT_W-1:0] upper_fen;
  logic [bps_pkg::PORT_W-1:0] upper_fout;
  logic [bps_pkg::PORT_W-1:0] upper_foe;
  logic [bps_pkg::PORT_W-1:0] lower_fen;
  logic [bps_pkg::PORT_W-1:0] lower_fout;
  logic [bps_pkg::PORT_W-1:0] lower_foe;
  logic [bps_pkg::PORT_W-1:0] ctrl_fen;
  logic [bps_pkg::PORT_W-1:0] ctrl_fout;
  logic [bps_pkg::PORT_W-1:0] ctrl_foe;
  logic                       wait_sel;
  logic                       bus_request_in_out_sel;

  always_comb
  begin
    upper_fen  = {bps_pkg::PORT_W{expanded}}; // [R01]
    upper_fout = core.data_out[bps_pkg::DBUS_W-1:bps_pkg::PORT_W];
    upper_foe  = {bps_pkg::PORT_W{core.data_oe}};
    lower_fen  = {bps_pkg::PORT_W{expanded && st.bus_ctrl.bus_width_16}}; // [R02]
    lower_fout = core.data_out[bps_pkg::PORT_W-1:0];
    lower_foe  = {bps_pkg::PORT_W{core.data_oe}};
    ctrl_fen   = {bps_pkg::PORT_W{1'b0}};
    ctrl_fout  = {bps_pkg::PORT_W{1'b0}};
    ctrl_foe   = {bps_pkg::PORT_W{1'b0}};
    // Request output wins if software sets both enables
    bus_request_in_out_sel = expanded && st.bus_ctrl.bus_request_out_enable;                       // [R08]
    wait_sel     = expanded && st.bus_ctrl.wait_input_enable && !bus_request_in_out_sel;           // [R07]
    // Clock pin: function only when its direction bit is set, all modes
    ctrl_fen[bps_pkg::PIN_CLK]  = st.ctrl_dir[bps_pkg::PIN_CLK];                         // [R03]
    ctrl_fout[bps_pkg::PIN_CLK] = core.sys_clk_level;
    ctrl_foe[bps_pkg::PIN_CLK]  = 1'b1;
    if (expanded)
    begin
      ctrl_fen[bps_pkg::PIN_AS]   = 1'b1;                                                // [R04]
      ctrl_fen[bps_pkg::PIN_RD]   = 1'b1;
      ctrl_fen[bps_pkg::PIN_HWR]  = 1'b1;
      ctrl_fen[bps_pkg::PIN_LWR]  = 1'b1;
      ctrl_fout[bps_pkg::PIN_AS]  = core.addr_strobe;
      ctrl_fout[bps_pkg::PIN_RD]  = core.read_strobe;
      ctrl_fout[bps_pkg::PIN_HWR] = core.high_byte_write_strobe;
      ctrl_fout[bps_pkg::PIN_LWR] = core.low_byte_write_strobe;
      ctrl_foe[bps_pkg::PIN_AS]   = 1'b1;
      ctrl_foe[bps_pkg::PIN_RD]   = 1'b1;
      ctrl_foe[bps_pkg::PIN_HWR]  = 1'b1;
      ctrl_foe[bps_pkg::PIN_LWR]  = 1'b1;
    end
    // Both enables clear leaves bit 2 to its direction bit
    ctrl_fen[bps_pkg::PIN_WAIT]  = wait_sel || bus_request_in_out_sel;                             // [R06]
    ctrl_fout[bps_pkg::PIN_WAIT] = bus_request_in_out_sel && core.bus_request_out;
    ctrl_foe[bps_pkg::PIN_WAIT]  = bus_request_in_out_sel;                                         // [R08]
    if (expanded && st.bus_ctrl.bus_release_enable)
    begin
      ctrl_fen[bps_pkg::PIN_GRANT]  = 1'b1;                                              // [R10]
      ctrl_fout[bps_pkg::PIN_GRANT] = core.bus_grant_out;
      ctrl_foe[bps_pkg::PIN_GRANT]  = 1'b1;
      ctrl_fen[bps_pkg::PIN_BUS_REQUEST_IN]   = 1'b1;
      ctrl_foe[bps_pkg::PIN_BUS_REQUEST_IN]   = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pin multiplexers
  // ----------------------------------------------------------------
  bps_pkg::bps_pad_s upper_pad;
  bps_pkg::bps_pad_s lower_pad;
  bps_pkg::bps_pad_s ctrl_pad;

  bps_port_mux u_upper
  (
    .func_en  (upper_fen),
    .func_out (upper_fout),
    .func_oe  (upper_foe),
    .dir      (st.upper_dir),
    .data     (st.upper_data),
    .pad      (upper_pad)
  );

  bps_port_mux u_lower
  (
    .func_en  (lower_fen),
    .func_out (lower_fout),
    .func_oe  (lower_foe),
    .dir      (st.lower_dir),
    .data     (st.lower_data),
    .pad      (lower_pad)
  );

  // Release disabled leaves bits 1 and 0 to the general I/O path
  bps_port_mux u_ctrl
  (
    .func_en  (ctrl_fen),
    .func_out (ctrl_fout),
    .func_oe  (ctrl_foe),
    .dir      (st.ctrl_dir),
    .data     (st.ctrl_data),
    .pad      (ctrl_pad)
  ); // [R09]

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  logic [bps_pkg::DATA_W-1:0] rd_value;
  logic                       rd_hit;

  always_comb
  begin
    rd_value = {bps_pkg::DATA_W{1'b0}};
    rd_hit   = 1'b1;
    case (paddr)
      bps_pkg::OFS_UPPER_DIR:  rd_value[bps_pkg::PORT_W-1:0] = st.upper_dir;
      bps_pkg::OFS_UPPER_DATA: rd_value[bps_pkg::PORT_W-1:0] = st.upper_data;
      bps_pkg::OFS_UPPER_PINS: rd_value[bps_pkg::PORT_W-1:0] = upper_pin_in;
      bps_pkg::OFS_LOWER_DIR:  rd_value[bps_pkg::PORT_W-1:0] = st.lower_dir;
      bps_pkg::OFS_LOWER_DATA: rd_value[bps_pkg::PORT_W-1:0] = st.lower_data;
      bps_pkg::OFS_LOWER_PINS: rd_value[bps_pkg::PORT_W-1:0] = lower_pin_in;
      bps_pkg::OFS_CTRLP_DIR:  rd_value[bps_pkg::PORT_W-1:0] = st.ctrl_dir;
      bps_pkg::OFS_CTRLP_DATA: rd_value[bps_pkg::PORT_W-1:0] = st.ctrl_data;
      bps_pkg::OFS_CTRLP_PINS: rd_value[bps_pkg::PORT_W-1:0] = ctrl_pin_in;
      bps_pkg::OFS_BUS_CTRL:   rd_value[3:0]                 = st.bus_ctrl;
      // Status: mode, expanded flag, legal flag, bit 2 wait and request output functions
      bps_pkg::OFS_STATUS:     rd_value[7:0] = {bus_request_in_out_sel, wait_sel, mode_legal, expanded,
                                                 1'b0, st.mode};
      default:                 rd_hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic access;
  logic do_write;

  always_comb
  begin
    next_st         = st;
    access          = psel && penable;
    do_write        = access && st.pready && pwrite && !st.pslverr;
    next_st.pready  = 1'b0;
    next_st.pslverr = 1'b0;
    // First edge after release: catch the strap and set clock pin direction
    if (!st.init_done)
    begin
      next_st.init_done                 = 1'b1;
      next_st.mode                      = mode_pins;                                     // [R13]
      next_st.ctrl_dir[bps_pkg::PIN_CLK] = strap_expanded;                               // [R03]
    end
    // Answer in the second access cycle; write lands on the pready edge
    if (access && !st.pready)
    begin
      next_st.pready  = 1'b1;
      next_st.pslverr = !rd_hit;
      next_st.prdata  = rd_value;
    end
    if (do_write)
    begin
      case (paddr)
        bps_pkg::OFS_UPPER_DIR:  next_st.upper_dir  = pwdata[bps_pkg::PORT_W-1:0];
        bps_pkg::OFS_UPPER_DATA: next_st.upper_data = pwdata[bps_pkg::PORT_W-1:0];
        bps_pkg::OFS_LOWER_DIR:  next_st.lower_dir  = pwdata[bps_pkg::PORT_W-1:0];
        bps_pkg::OFS_LOWER_DATA: next_st.lower_data = pwdata[bps_pkg::PORT_W-1:0];
        bps_pkg::OFS_CTRLP_DIR:  next_st.ctrl_dir   = pwdata[bps_pkg::PORT_W-1:0];
        bps_pkg::OFS_CTRLP_DATA: next_st.ctrl_data  = pwdata[bps_pkg::PORT_W-1:0];
        bps_pkg::OFS_BUS_CTRL:   next_st.bus_ctrl   = pwdata[3:0];
        default:                 next_st.init_done  = 1'b1;
      endcase
    end
    // Pads and core-facing inputs, one register stage
    next_st.upper_pad   = upper_pad;
    next_st.lower_pad   = lower_pad;
    next_st.ctrl_pad    = ctrl_pad;
    next_st.data_bus_in = {upper_pin_in, lower_pin_in};
    next_st.wait_in        = wait_sel && ctrl_pin_in[bps_pkg::PIN_WAIT];                 // [R07]
    next_st.bus_request_in = expanded && st.bus_ctrl.bus_release_enable
                             && ctrl_pin_in[bps_pkg::PIN_BUS_REQUEST_IN];                          // [R10]
    // Interrupt feeds: bit 3 only where it is not the write strobe
    next_st.ext_interrupt[3] = !expanded && ctrl_pin_in[bps_pkg::PIN_LWR];               // [R05]
    next_st.ext_interrupt[2] = ctrl_pin_in[bps_pkg::PIN_WAIT];                           // [R06]
    next_st.ext_interrupt[1] = ctrl_pin_in[bps_pkg::PIN_GRANT];                          // [R11]
    next_st.ext_interrupt[0] = ctrl_pin_in[bps_pkg::PIN_BUS_REQUEST_IN];                           // [R11]
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Reset mode is single-chip so every pin stays an input until the strap lands
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st            <= '0;
      st.mode       <= bps_pkg::MODE_RESET;
      st.upper_dir  <= bps_pkg::DIR_RESET;
      st.upper_data <= bps_pkg::DATA_RESET;
      st.lower_dir  <= bps_pkg::DIR_RESET;
      st.lower_data <= bps_pkg::DATA_RESET;
      st.ctrl_dir   <= bps_pkg::DIR_RESET;
      st.ctrl_data  <= bps_pkg::DATA_RESET;
      st.bus_ctrl   <= bps_pkg::CTRL_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata         = st.prdata;
  assign pready         = st.pready;
  assign pslverr        = st.pslverr;
  assign upper_pin_out  = st.upper_pad.out;
  assign upper_pin_oe   = st.upper_pad.oe;
  assign lower_pin_out  = st.lower_pad.out;
  assign lower_pin_oe   = st.lower_pad.oe;
  assign ctrl_pin_out   = st.ctrl_pad.out;
  assign ctrl_pin_oe    = st.ctrl_pad.oe;
  assign data_bus_in    = st.data_bus_in;
  assign wait_in        = st.wait_in;
  assign bus_request_in = st.bus_request_in;
  assign ext_interrupt  = st.ext_interrupt;

endmodule : bps_pin_select

// ### verif/bps_pin_select_assertions.sv
// Concurrent checks on the pin function select ports.
// Assumes the mode strap is steady from reset release onward.
`timescale 1ns/1ps
module bps_pin_select_assertions
(
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pready,
  input wire logic [2:0]         mode_pins,
  input wire bps_pkg::bps_core_s core,
  input wire logic [7:0]         upper_pin_in,
  input wire logic [7:0]         lower_pin_in,
  input wire logic [7:0]         ctrl_pin_in,
  input wire logic [7:0]         upper_pin_out,
  input wire logic [7:0]         upper_pin_oe,
  input wire logic [7:0]         ctrl_pin_out,
  input wire logic [7:0]         ctrl_pin_oe,
  input wire logic [15:0]        data_bus_in,
  input wire logic               wait_in,
  input wire logic               bus_request_in,
  input wire logic [3:0]         ext_interrupt
);
  logic [2:0] cnt;
  logic [2:0] mode_q;
  logic       exp;
  // Own copy of the strap; pads only settle a few edges after release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt    <= 3'h0;
      mode_q <= 3'h7;
    end
    else
    begin
      if (cnt == 3'h0)
        mode_q <= mode_pins;
      if (cnt != 3'h4)
        cnt <= cnt + 3'h1;
    end
  end
  assign exp = (mode_q != 3'h3) && (mode_q != 3'h7) && (mode_q != 3'h0);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  upper_bus_a: assert property (cnt[2] && exp |->
    upper_pin_oe == {8{$past(core.data_oe)}} && upper_pin_out == $past(core.data_out[15:8]))
    else $error("upper port not on data bus");
  data_in_a: assert property ($past(presetn) |-> data_bus_in == $past({upper_pin_in, lower_pin_in}))
    else $error("data bus input mismatch");
  strobe_pins_a: assert property (cnt[2] && exp |->
    ctrl_pin_oe[6:3] == 4'hF && ctrl_pin_out[6:3] == $past(core[6:3])) else $error("strobe pins wrong");
  irq_low_a: assert property ($past(presetn) |-> ext_interrupt[2:0] == $past(ctrl_pin_in[2:0]))
    else $error("interrupt inputs 2..0 wrong");
  irq_high_a: assert property (cnt[2] |-> ext_interrupt[3] == ($past(ctrl_pin_in[3]) && !exp))
    else $error("interrupt input 3 wrong");
  bus_request_in_in_a: assert property (bus_request_in |-> exp && $past(ctrl_pin_in[0]))
    else $error("bus request input wrong");
  wait_in_a: assert property (wait_in |-> exp && $past(ctrl_pin_in[2]))
    else $error("wait input wrong");
  clk_dir_a: assert property (cnt == 3'h3 |=> ctrl_pin_oe[7] == exp)
    else $error("clock pin direction reset wrong");
  clk_out_a: assert property (cnt[2] && ctrl_pin_oe[7] |-> ctrl_pin_out[7] == $past(core.sys_clk_level))
    else $error("clock pin not driving clock");
  ready_pulse_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("ready not a single pulse");
endmodule : bps_pin_select_assertions
bind bps_pin_select bps_pin_select_assertions u_chk
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready), .mode_pins(mode_pins),
  .core(core), .upper_pin_in(upper_pin_in), .lower_pin_in(lower_pin_in), .ctrl_pin_in(ctrl_pin_in),
  .upper_pin_out(upper_pin_out), .upper_pin_oe(upper_pin_oe), .ctrl_pin_out(ctrl_pin_out),
  .ctrl_pin_oe(ctrl_pin_oe), .data_bus_in(data_bus_in), .wait_in(wait_in), .bus_request_in(bus_request_in),
  .ext_interrupt(ext_interrupt)
);

// ### verif/bps_bus_partner.sv
// Far side of the pads: memory, peripherals and a second bus master.
// Assumes the bench commands which pads it drives and with what level.
`timescale 1ns/1ps
module bps_bus_partner
(
  input  wire logic        pclk,
  input  wire logic [23:0] pad_out,
  input  wire logic [23:0] pad_oe,
  input  wire logic [23:0] ext_val,
  input  wire logic [23:0] ext_oe,
  output logic      [23:0] pin_in
);
  logic tog = 1'b0;
  always @(posedge pclk)
    tog <= ~tog;
  // Data pads float high on pull-ups; control pads have none, so they wander
  always_comb
    for (int i = 0; i < 24; i++)
      pin_in[i] = pad_oe[i] ? pad_out[i] : ext_oe[i] ? ext_val[i] : (i < 8) ? tog : 1'b1;
endmodule : bps_bus_partner

// ### verif/bps_pin_select_tb.sv
// Self-checking bench for the pin function select block.
// Assumes the partner model on the pads and the bound checker.
`timescale 1ns/1ps
module bps_pin_select_tb;
  logic               pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0, prdata, rd;
  logic               pready, pslverr, wait_in, bus_request_in, re, e;
  logic [2:0]         mode_pins = 3'h7;
  bps_pkg::bps_core_s core = 24'hA55AD0;
  logic [7:0]         upper_pin_out, upper_pin_oe, lower_pin_out, lower_pin_oe, ctrl_pin_out, ctrl_pin_oe;
  logic [23:0]        pins, ext_val = 24'h0, ext_oe = 24'h0;
  logic [15:0]        data_bus_in;
  logic [3:0]         ext_interrupt;
  int                 bad_count = 0, n_compared = 0, cycles = 0;
  bps_pin_select dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mode_pins(mode_pins), .core(core),
    .upper_pin_in(pins[23:16]), .upper_pin_out(upper_pin_out), .upper_pin_oe(upper_pin_oe),
    .lower_pin_in(pins[15:8]), .lower_pin_out(lower_pin_out), .lower_pin_oe(lower_pin_oe),
    .ctrl_pin_in(pins[7:0]), .ctrl_pin_out(ctrl_pin_out), .ctrl_pin_oe(ctrl_pin_oe),
    .data_bus_in(data_bus_in), .wait_in(wait_in), .bus_request_in(bus_request_in), .ext_interrupt(ext_interrupt)
  );
  bps_bus_partner partner
  (
    .pclk(pclk), .pad_out({upper_pin_out, lower_pin_out, ctrl_pin_out}),
    .pad_oe({upper_pin_oe, lower_pin_oe, ctrl_pin_oe}), .ext_val(ext_val), .ext_oe(ext_oe), .pin_in(pins)
  );
  always #5 pclk = ~pclk;
  // Toggling clock level exposes a clock pin stuck on a register
  always @(posedge pclk)
  begin
    core.sys_clk_level <= ~core.sys_clk_level;
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      bad_count++;
      finish_test();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : chk
  // Idle cycle first, so a release and a new setup never share a time step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
    repeat (3) @(posedge pclk);
  endtask : wr
  task automatic boot(input logic [2:0] m);
    presetn <= 1'b0;
    mode_pins <= m;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
  endtask : boot
  task automatic finish_test();
    $display("Compared %0d values, %0d mismatches", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test
  initial
  begin
    for (int m = 1; m < 8; m++)
    begin
      e = (m != 3) && (m != 7);
      boot(3'(m));
      apb(1'b0, 8'h28, 32'h0);
      chk({rd[5:4], rd[2:0]}, {1'b1, e, 3'(m)});
      apb(1'b0, 8'h18, 32'h0);
      chk({rd[7], ctrl_pin_oe[7]}, {2{e}});
      chk(upper_pin_oe, {8{e}});
      wr(8'h00, 8'h0F);
      wr(8'h04, 8'h3C);
      chk(upper_pin_oe, e ? 8'hFF : 8'h0F);
      chk(upper_pin_out & upper_pin_oe, e ? 8'hA5 : 8'h0C);
      wr(8'h0C, 8'h0F);
      wr(8'h10, 8'h3C);
      wr(8'h24, 8'h08);
      chk(lower_pin_oe, e ? 8'hFF : 8'h0F);
      chk(lower_pin_out & lower_pin_oe, e ? 8'h5A : 8'h0C);
      wr(8'h24, 8'h00);
      chk(lower_pin_oe, 8'h0F);
      ext_oe <= 24'h00000F;
      ext_val <= 24'h000009;
      wr(8'h18, 8'h90);
      chk(ctrl_pin_oe[6:3], e ? 4'hF : 4'h2);
      chk(e ? ctrl_pin_out[6:3] : 4'hA, 4'hA);
      chk(ext_interrupt, e ? 4'h1 : 4'h9);
      ext_oe <= 24'h0;
    end
    boot(3'h5);
    mode_pins <= 3'h3;
    wr(8'h18, 8'h87);
    wr(8'h1C, 8'h05);
    chk({ctrl_pin_oe[2:0], ctrl_pin_out[2:0], wait_in}, 7'b1111010);
    ext_oe <= 24'h4;
    ext_val <= 24'h4;
    wr(8'h24, 8'h01);
    chk({ctrl_pin_oe[2], wait_in, ext_interrupt[2]}, 3'b011);
    apb(1'b0, 8'h28, 32'h0);
    chk({rd[7:6], rd[2:0]}, 5'b01101);
    core.bus_request_out <= 1'b1;
    wr(8'h24, 8'h02);
    chk({ctrl_pin_oe[2], ctrl_pin_out[2], wait_in}, 3'b110);
    ext_oe <= 24'h1;
    ext_val <= 24'h1;
    core.bus_grant_out <= 1'b1;
    wr(8'h24, 8'h04);
    chk({ctrl_pin_oe[2:0], ctrl_pin_out[1], bus_request_in}, 5'b11011);
    apb(1'b1, 8'h28, 32'hFF);
    apb(1'b0, 8'h2C, 32'h0);
    chk({re, rd}, {1'b1, 32'h0});
    apb(1'b0, 8'h28, 32'h0);
    chk(rd[2:0], 3'h5);
    finish_test();
  end
endmodule : bps_pin_select_tb
